// ===== design/sac_defs.svh
// Constants for the successive-approximation converter control block
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

`define SAC_RES_W 8
`define SAC_SRC_N 14
`define SAC_RES_RST 8'h00
`define SAC_TRIAL_MSB 8'h80
// ----------------------------------------
// Channel codes
// ----------------------------------------
`define SAC_CHS_PIN_LAST 4'hB
`define SAC_CHS_TEMP 4'hE
`define SAC_CHS_FREF 4'hF
`define SAC_SRC_TEMP 14'h1000
`define SAC_SRC_FREF 14'h2000
// ----------------------------------------
// Clock select codes and divider limits
// ----------------------------------------
`define SAC_CKS_DIV2 3'h0
`define SAC_CKS_DIV4 3'h4
`define SAC_CKS_DIV8 3'h1
`define SAC_CKS_DIV16 3'h5
`define SAC_CKS_DIV32 3'h2
`define SAC_CKS_DIV64 3'h6
`define SAC_CKS_RC_LOW 2'h3
`define SAC_LIM_DIV2 6'h01
`define SAC_LIM_DIV4 6'h03
`define SAC_LIM_DIV8 6'h07
`define SAC_LIM_DIV16 6'h0F
`define SAC_LIM_DIV32 6'h1F
`define SAC_LIM_DIV64 6'h3F
// ----------------------------------------
// Sequence length in bit periods and last bit count
// ----------------------------------------
`define SAC_PERIODS 4'hA
`define SAC_LAST_BIT 3'h7

`endif

// ===== design/sac_pkg.sv
// Types shared by the converter control modules
`include "sac_defs.svh"

package sac_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DISC, ST_BITS, ST_XFER} sac_state_e;
  typedef logic [`SAC_RES_W-1:0] sac_word_t;
  typedef logic [`SAC_SRC_N-1:0] sac_src_t;
endpackage : sac_pkg

// ===== design/sac_tick.sv
// Bit-period tick generator from the system clock or the synced RC clock
`include "sac_defs.svh"

module sac_tick (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [2:0] cks_i,
  input wire logic restart_i,
  input wire logic rc_edge_i,
  output logic tick_o
);
  import sac_pkg::*;

  logic [5:0] cnt_q;
  logic [5:0] lim;
  logic rc_sel;

  assign rc_sel = (cks_i[1:0] == `SAC_CKS_RC_LOW);

  always_comb begin
    lim = `SAC_LIM_DIV2;
    case (cks_i)
      `SAC_CKS_DIV4: lim = `SAC_LIM_DIV4;
      `SAC_CKS_DIV8: lim = `SAC_LIM_DIV8;
      `SAC_CKS_DIV16: lim = `SAC_LIM_DIV16;
      `SAC_CKS_DIV32: lim = `SAC_LIM_DIV32;
      `SAC_CKS_DIV64: lim = `SAC_LIM_DIV64;
      default: lim = `SAC_LIM_DIV2;
    endcase
  end

  // RC ticks cannot be realigned to a start, so the first RC period is short
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= 6'h00;
      tick_o <= 1'b0;
    end else if (rc_sel) begin
      cnt_q <= 6'h00;
      tick_o <= rc_edge_i;
    end else if (restart_i || cnt_q >= lim) begin
      cnt_q <= 6'h00;
      tick_o <= !restart_i;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      tick_o <= 1'b0;
    end
  end

  a_div4_period: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    tick_o && cks_i == `SAC_CKS_DIV4 && !restart_i
    ##1 (cks_i == `SAC_CKS_DIV4 && !restart_i)[*3] |=> tick_o)
    else $error("divide by four tick spacing wrong");
endmodule : sac_tick

// ===== design/sac_sar.sv
// Successive-approximation register, most significant bit first
`include "sac_defs.svh"

module sac_sar (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic decide_i,
  input wire logic cmp_i,
  output sac_pkg::sac_word_t trial_o,
  output sac_pkg::sac_word_t bits_o,
  output sac_pkg::sac_word_t mask_o,
  output logic last_o
);
  import sac_pkg::*;

  sac_word_t ptr_q;
  sac_word_t bits_d;
  sac_word_t ptr_d;

  assign bits_d = cmp_i ? (bits_o | ptr_q) : bits_o;
  assign ptr_d = ptr_q >> 1;

  always_ff @(posedge mclk_i) begin
    if (rst_i || load_i) begin
      ptr_q <= `SAC_TRIAL_MSB;
      bits_o <= `SAC_RES_RST;
      mask_o <= `SAC_RES_RST;
      last_o <= 1'b0;
      trial_o <= `SAC_TRIAL_MSB;
    end else if (decide_i) begin
      ptr_q <= ptr_d;
      bits_o <= bits_d;
      mask_o <= mask_o | ptr_q;
      last_o <= cmp_i;
      trial_o <= bits_d | ptr_d;
    end
  end

  a_keep_decided: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !load_i && !decide_i |=> $stable(bits_o) && $stable(mask_o))
    else $error("resolved bits changed without a decision");
endmodule : sac_sar

// ===== design/sac_ctrl.sv
// Top of the converter control: channel mux, sequencer, flag and wake
`include "sac_defs.svh"

module sac_ctrl (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic converter_enable_i,
  input wire logic conv_go_set_i,
  input wire logic conv_go_clear_i,
  input wire logic [3:0] channel_select_i,
  input wire logic [2:0] conv_clock_select_i,
  input wire logic conv_done_flag_clear_i,
  input wire logic conv_done_irq_enable_i,
  input wire logic global_irq_enable_i,
  input wire logic peripheral_irq_enable_i,
  input wire logic sleep_i,
  input wire logic dedicated_rc_clock_i,
  input wire logic comparator_i,
  output logic conv_go_busy_o,
  output logic conv_done_flag_o,
  output sac_pkg::sac_word_t conversion_result_o,
  output sac_pkg::sac_src_t source_select_o,
  output logic sample_hold_o,
  output sac_pkg::sac_word_t dac_code_o,
  output logic irq_o,
  output logic wake_o,
  output logic isr_branch_o,
  output logic resume_inline_o
);
  import sac_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  sac_state_e state_q;
  logic enable_q;
  logic rc_s1_q;
  logic rc_s2_q;
  logic rc_s3_q;
  logic cmp_s1_q;
  logic cmp_s2_q;
  logic [2:0] bits_q;
  logic [3:0] per_cnt_q;
  logic tick;
  logic rc_sel;
  logic start;
  logic abort_sw;
  logic halt;
  logic kill;
  logic done_evt;
  logic decide;
  logic flag_d;
  logic irq_en_all;
  sac_src_t src_d;
  sac_word_t sar_bits;
  sac_word_t sar_mask;
  sac_word_t sar_trial;
  sac_word_t fill;
  logic sar_last;

  assign rc_sel = (conv_clock_select_i[1:0] == `SAC_CKS_RC_LOW);
  assign irq_en_all = global_irq_enable_i && peripheral_irq_enable_i;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // RC clock is sampled as a level, not used as a clock: one domain only
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      rc_s1_q <= dedicated_rc_clock_i;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  // Comparator is analog, hence asynchronous to the decision tick
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= comparator_i;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // Enable must be seen set a cycle before go is accepted
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= converter_enable_i;
    end
  end

  // ----------------------------------------
  // Source multiplexer select
  // ----------------------------------------
  always_comb begin
    src_d = '0;
    if (channel_select_i <= `SAC_CHS_PIN_LAST) begin
      src_d[channel_select_i] = 1'b1;
    end else if (channel_select_i == `SAC_CHS_TEMP) begin
      src_d = `SAC_SRC_TEMP;
    end else if (channel_select_i == `SAC_CHS_FREF) begin
      src_d = `SAC_SRC_FREF;
    end
  end

  // One select feeds the single sample-and-hold; unused codes pick nothing
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      source_select_o <= '0;
    end else begin
      source_select_o <= src_d;
    end
  end

  // Hold capacitor tracks the source only while idle and enabled
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sample_hold_o <= 1'b0;
    end else begin
      sample_hold_o <= converter_enable_i && state_q == ST_IDLE
        && !start;
    end
  end

  // ----------------------------------------
  // Bit period and approximation register
  // ----------------------------------------
  sac_tick u_tick (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .cks_i(conv_clock_select_i),
    .restart_i(start),
    .rc_edge_i(rc_s2_q && !rc_s3_q),
    .tick_o(tick)
  );

  assign decide = (state_q == ST_BITS) && tick;

  sac_sar u_sar (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(start),
    .decide_i(decide),
    .cmp_i(cmp_s2_q),
    .trial_o(sar_trial),
    .bits_o(sar_bits),
    .mask_o(sar_mask),
    .last_o(sar_last)
  );

  // Unresolved bits repeat the last decision
  for (genvar i = 0; i < `SAC_RES_W; i++) begin : g_fill
    assign fill[i] = sar_mask[i] ? sar_bits[i] : sar_last;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dac_code_o <= `SAC_RES_RST;
    end else begin
      dac_code_o <= sar_trial;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Go written while already converting is ignored
  assign start = conv_go_set_i && enable_q && !conv_go_busy_o
    && !(sleep_i && !rc_sel);
  assign abort_sw = conv_go_clear_i && state_q != ST_IDLE;
  assign halt = sleep_i && !rc_sel && state_q != ST_IDLE;
  assign kill = abort_sw || halt || !enable_q;
  assign done_evt = state_q == ST_XFER && tick && !kill;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      bits_q <= 3'h0;
    end else if (kill) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_DISC;
          end
        end
        ST_DISC: begin
          if (tick) begin
            state_q <= ST_BITS;
            bits_q <= 3'h0;
          end
        end
        ST_BITS: begin
          if (tick) begin
            bits_q <= bits_q + 3'h1;
            if (bits_q == `SAC_LAST_BIT) begin
              state_q <= ST_XFER;
            end
          end
        end
        ST_XFER: begin
          if (tick) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Sleep on a divided clock stops the work; result is left untouched
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      conv_go_busy_o <= 1'b0;
    end else if (start) begin
      conv_go_busy_o <= 1'b1;
    end else if (done_evt || kill) begin
      conv_go_busy_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      conversion_result_o <= `SAC_RES_RST;
    end else if (done_evt || (abort_sw && enable_q)) begin
      conversion_result_o <= fill;
    end
  end

  // ----------------------------------------
  // Done flag, interrupt and wake
  // ----------------------------------------
  // A completion in the clearing cycle keeps the flag set
  assign flag_d = done_evt || (conv_done_flag_o
    && !conv_done_flag_clear_i);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      conv_done_flag_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      conv_done_flag_o <= flag_d;
      irq_o <= flag_d && conv_done_irq_enable_i;
    end
  end

  // Core runs the next instruction itself; these only steer the resume
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
      isr_branch_o <= 1'b0;
      resume_inline_o <= 1'b0;
    end else begin
      wake_o <= done_evt && sleep_i && conv_done_irq_enable_i;
      isr_branch_o <= done_evt && sleep_i && conv_done_irq_enable_i
        && irq_en_all;
      resume_inline_o <= done_evt && sleep_i && conv_done_irq_enable_i
        && !irq_en_all;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i || start) begin
      per_cnt_q <= 4'h0;
    end else if (tick && state_q != ST_IDLE) begin
      per_cnt_q <= per_cnt_q + 4'h1;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_done;
    done_evt ##1 1'b1;
  endsequence

  a_start_enable: assert property (
    $rose(conv_go_busy_o) |-> $past(enable_q) && $past(conv_go_set_i))
    else $error("conversion started without prior enable");

  a_ten_periods: assert property (
    done_evt |-> per_cnt_q == `SAC_PERIODS - 4'h1)
    else $error("conversion length is not ten bit periods");

  a_done_effects: assert property (
    s_done |-> !conv_go_busy_o && conv_done_flag_o
      && conversion_result_o == $past(sar_bits))
    else $error("completion effects missing");

  a_flag_sticky: assert property (
    conv_done_flag_o && !conv_done_flag_clear_i |=> conv_done_flag_o)
    else $error("done flag cleared by hardware");

  a_flag_always: assert property (
    done_evt && !conv_done_irq_enable_i |=> conv_done_flag_o && !irq_o)
    else $error("flag not set with interrupt disabled");

  a_irq_gate: assert property (
    irq_o |-> conv_done_flag_o && $past(conv_done_irq_enable_i))
    else $error("interrupt without flag and enable");

  a_msb_first: assert property (
    start |=> sar_trial == `SAC_TRIAL_MSB ##1 dac_code_o == `SAC_TRIAL_MSB)
    else $error("approximation did not begin at top bit");

  a_sleep_abort: assert property (
    halt |=> !conv_go_busy_o && state_q == ST_IDLE
      && $stable(conversion_result_o))
    else $error("divided clock conversion ran in sleep");

  a_abort_fill: assert property (
    abort_sw && enable_q && !done_evt |=> (conversion_result_o
      & ~$past(sar_mask)) == ($past(sar_last) ? ~$past(sar_mask) : 8'h00))
    else $error("partial result fill wrong");

  a_wake_route: assert property (
    wake_o |-> isr_branch_o ^ resume_inline_o)
    else $error("wake without a single resume path");

  a_src_onehot: assert property (
    $onehot0(source_select_o))
    else $error("more than one source selected");
endmodule : sac_ctrl

// ===== verif/tb_sar_adc_conversion_control.sv
// Self-checking bench for the converter control top
module tb_sar_adc_conversion_control import sac_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic en = 1'b0, go_set = 1'b0, go_clr = 1'b0, flag_clr = 1'b0;
  logic [3:0] chan = 4'h0;
  logic [2:0] clk_sel = 3'h0;
  logic irq_en = 1'b0, global_irq_enable = 1'b0, pie = 1'b0, sleep = 1'b0;
  logic rc_clk = 1'b0, comparator_i = 1'b0;
  logic busy, flag, irq, wake, isr, inline_go, hold;
  sac_word_t result, dac;
  sac_src_t src;
  logic [7:0] vin = 8'h00;
  int err_total = 0, num_checks = 0;
  bit saw_wake, saw_isr, saw_inline;

  always #12.5 mclk_i = ~mclk_i;
  // RC oscillator free-runs, unrelated in phase to the system clock
  always #130 rc_clk = ~rc_clk;
  // Comparator model: high while the held input is at or above the trial
  always @(negedge mclk_i) comparator_i <= (vin >= dac);
  always @(negedge mclk_i) begin
    if (wake === 1'b1) saw_wake = 1'b1;
    if (isr === 1'b1) saw_isr = 1'b1;
    if (inline_go === 1'b1) saw_inline = 1'b1;
  end

  sac_ctrl dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .converter_enable_i(en),
    .conv_go_set_i(go_set), .conv_go_clear_i(go_clr),
    .channel_select_i(chan), .conv_clock_select_i(clk_sel),
    .conv_done_flag_clear_i(flag_clr), .conv_done_irq_enable_i(irq_en),
    .global_irq_enable_i(global_irq_enable), .peripheral_irq_enable_i(pie),
    .sleep_i(sleep), .dedicated_rc_clock_i(rc_clk),
    .comparator_i(comparator_i), .conv_go_busy_o(busy),
    .conv_done_flag_o(flag), .conversion_result_o(result),
    .source_select_o(src), .sample_hold_o(hold), .dac_code_o(dac),
    .irq_o(irq), .wake_o(wake), .isr_branch_o(isr),
    .resume_inline_o(inline_go)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : cyc

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic check_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h..%0h", $time, got,
               lo, hi);
    end
  endtask : check_rng

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse

  task automatic start();
    int n;
    begin
      n = 0;
      pulse(go_set);
      while (busy !== 1'b1 && n < 4) begin
        cyc(1);
        n++;
      end
      check(busy, 1'b1);
      check(hold, 1'b0);
    end
  endtask : start

  task automatic wait_idle(output int len);
    len = 0;
    while (busy === 1'b1 && len < 3000) begin
      cyc(1);
      len++;
    end
  endtask : wait_idle

  // Full conversion; a settle wait before go models acquisition time
  task automatic convert(input logic [2:0] cks, input logic [7:0] v,
                         input int lo, input int hi, input bit chk);
    int len;
    begin
      clk_sel = cks;
      vin = v;
      cyc(4);
      start();
      wait_idle(len);
      check_rng(len, lo, hi);
      check(flag, 1'b1);
      check(irq, irq_en);
      if (chk) check(result, v);
      cyc(6);
      check(flag, 1'b1);
      pulse(flag_clr);
      cyc(1);
      check(flag, 1'b0);
      check(irq, 1'b0);
    end
  endtask : convert

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  logic [2:0] codes [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  logic [7:0] vals [6] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h3C, 8'hC3};
  int len;
  sac_src_t exp_src;

  initial begin
    cyc(2);
    rst_i = 1'b0;
    cyc(1);
    check(busy, 1'b0);
    check(flag, 1'b0);
    check(result, 8'h00);
    check(irq, 1'b0);
    // Go in the same write that turns the converter on is refused
    en = 1'b1;
    go_set = 1'b1;
    cyc(1);
    go_set = 1'b0;
    cyc(3);
    check(busy, 1'b0);
    check(hold, 1'b1);
    for (int c = 0; c < 16; c++) begin
      chan = c[3:0];
      cyc(2);
      exp_src = '0;
      if (c <= 11) exp_src[c] = 1'b1;
      if (c == 14) exp_src[12] = 1'b1;
      if (c == 15) exp_src[13] = 1'b1;
      check(src, exp_src);
    end
    // Every divided clock; the comparator needs periods of 4 or more, results checked from 8
    for (int i = 0; i < 6; i++) begin
      irq_en = i[0];
      convert(codes[i], vals[i], 20 * (1 << i) - 2, 20 * (1 << i) + 3,
              i >= 2);
    end
    // Both RC codes, period about 10.4 cycles; fast core, so only in Sleep
    sleep = 1'b1;
    convert(3'h3, 8'h81, 80, 115, 1'b1);
    convert(3'h7, 8'h7E, 80, 115, 1'b1);
    sleep = 1'b0;
    // Abort mid-run: two bits resolved, rest copy the last
    clk_sel = 3'h6;
    vin = 8'hBF;
    cyc(4);
    start();
    cyc(224);
    pulse(go_clr);
    cyc(2);
    check(busy, 1'b0);
    check(result, 8'h80);
    check(flag, 1'b0);
    vin = 8'h40;
    cyc(4);
    start();
    cyc(224);
    pulse(go_clr);
    cyc(2);
    check(result, 8'h7F);
    // Sleep on a divided clock: start refused, running one stopped
    sleep = 1'b1;
    pulse(go_set);
    cyc(3);
    check(busy, 1'b0);
    sleep = 1'b0;
    start();
    cyc(100);
    sleep = 1'b1;
    cyc(3);
    check(busy, 1'b0);
    check(flag, 1'b0);
    check(result, 8'h7F);
    // Converter switched off mid-run: stops, no flag, result kept
    sleep = 1'b0;
    start();
    cyc(100);
    en = 1'b0;
    cyc(3);
    check(busy, 1'b0);
    check(flag, 1'b0);
    check(result, 8'h7F);
    en = 1'b1;
    sleep = 1'b1;
    // RC clock in Sleep: wake then service, wake then in-line resume, or no wake with the interrupt off
    for (int k = 0; k < 3; k++) begin
      irq_en = (k != 2);
      global_irq_enable = (k == 0);
      pie = (k == 0);
      clk_sel = 3'h3;
      vin = 8'h66;
      saw_wake = 1'b0;
      saw_isr = 1'b0;
      saw_inline = 1'b0;
      cyc(4);
      start();
      wait_idle(len);
      cyc(2);
      check(result, 8'h66);
      check(flag, 1'b1);
      check(saw_wake, irq_en);
      check(saw_isr, k == 0);
      check(saw_inline, k == 1);
      pulse(flag_clr);
    end
    sleep = 1'b0;
    give_verdict();
  end

  initial begin
    #500000;
    err_total++;
    give_verdict();
  end
endmodule : tb_sar_adc_conversion_control
